/* rtl/tte_engine.sv */
// Purpose: controller-side bookkeeping for one write/read timeslot pair
// Assumes: host beats and link slots come from logic on ref_clk_in
// Notes:   frame_in pulses once per frame; link strobes are one cycle
//
// What this block does
// - Flags are read-only; a one written clears only that flag, except the summary clear, which clears both summary flags.
// - Clearing the received flag withholds acknowledgement for that item.
// - Clearing write send-pending cancels, frees buffer, toggles outgoing bit.
// - Node read transactions retry until done; node software cannot abort.
// - Node send-pending clear withdraws only not-yet-started queued item.
// - Nothing to send means transmit two idle items, index FF ones.
// - Idle slots always accepted, never acknowledged, never touch flags.
// - Index FF item is idle only when its value is all ones.
// - Both indexes FF but not idle still sets send-pending.
// - Toggle bits reset to a fixed value, untrusted until a synchronizing transaction.
// - Both indexes at least F0 means synchronizing; skip toggle check.
// - Node applies synchronizing control writes immediately, no received flag.
// - Controller accepts synchronizing only while received flag is clear.
// - Accepted synchronizing loads packet toggle as last incoming toggle.
// - Buffer write sets send-pending; writes ignored while it is set.
// - Send-pending set only if hotspot written and a non-FF byte.
// - Send buffer with toggle every frame until matching acknowledgement.
// - Write hotspot is the final byte of the buffer.
// - Reading either final two bytes clears the received flag.
// - Node accepts write only if flags clear and toggle differs or both indexes are synchronizing.
// - Matching acknowledgement clears send-pending, sets summary, toggles bit.
`timescale 1ns/10ps
`default_nettype none
module tte_engine (
   // Clock and reset
   input  wire logic              ref_clk_in,
   input  wire logic              sys_rst_in,
   // Host byte port
   input  wire tte_pkg::tte_spi_s spi_in,
   output logic [7:0]             spi_rdata_out,
   // Software flag clears, write one to clear
   input  wire logic              clr_send_pending_in,
   input  wire logic              clr_receive_full_in,
   input  wire logic              clr_summary_in,
   // Flags seen by software
   output logic                   send_pending_out,
   output logic                   receive_full_out,
   output logic                   summary_sent_out,
   output logic                   summary_receive_full_flag_out,
   // Link: frame tick, outgoing write slot
   input  wire logic              frame_in,
   output logic                   tx_valid_out,
   output tte_pkg::tte_slot_s     tx_slot_out,
   // Link: incoming read slot with acknowledgement
   input  wire logic              rx_valid_in,
   input  wire tte_pkg::tte_slot_s rx_slot_in,
   input  wire logic              rx_ack_in,
   input  wire logic              rx_ack_toggle_in,
   // Acknowledgement returned for the read slot
   output logic                   ack_out,
   output logic                   ack_toggle_out
);
   typedef struct packed {
      logic [tte_pkg::SLOT_BYTES*8-1:0] wbuf;
      logic [tte_pkg::SLOT_BYTES*8-1:0] rbuf;
      logic       send_pending;
      logic       receive_full;
      logic       sum_sent;
      logic       sum_receive_full_flag;
      logic       out_toggle;
      logic       in_toggle;
      logic       in_active;
      logic       saw_hot;
      logic       saw_non_ff;
      logic       blocked;
      logic       ack;
      logic       tx_valid;
      tte_pkg::tte_slot_s tx_slot;
      logic [7:0] rdata;
   } tte_state_s;

   tte_state_s st_reg;
   tte_state_s st_next;

   function automatic logic is_idle_item(input tte_pkg::tte_item_s it);
      is_idle_item = (it.index == tte_pkg::IDLE_INDEX) &&
                     (it.value == tte_pkg::IDLE_VALUE);
   endfunction

   function automatic logic [7:0] buf_byte(
      input logic [tte_pkg::SLOT_BYTES*8-1:0] b, input logic [3:0] a);
      buf_byte = b[(tte_pkg::SLOT_BYTES-1-int'(a))*8 +: 8];
   endfunction

   logic       rx_idle;
   logic       rx_sync;
   logic       rx_accept;
   tte_pkg::tte_slot_s wslot;

   always_comb begin
      rx_idle = is_idle_item(rx_slot_in.item_hi) &&
                is_idle_item(rx_slot_in.item_lo);
      rx_sync = (rx_slot_in.item_hi.index >= tte_pkg::SYNC_MIN) &&
                (rx_slot_in.item_lo.index >= tte_pkg::SYNC_MIN);
      // Sync needs only an empty buffer; normal also needs a new toggle
      rx_accept = rx_valid_in && !rx_idle && !st_reg.receive_full &&
                  (rx_sync ||
                   (rx_slot_in.toggle != st_reg.in_toggle));
      wslot = tte_pkg::tte_slot_s'({st_reg.wbuf, st_reg.out_toggle});
   end

   always_comb begin
      st_next = st_reg;
      st_next.tx_valid = 1'b0;
      // Host transfer: gate writes once send-pending is already set
      if (spi_in.start) begin
         st_next.saw_hot    = 1'b0;
         st_next.saw_non_ff = 1'b0;
         st_next.blocked    = st_reg.send_pending;
      end
      if (spi_in.wr && !(spi_in.start ? st_reg.send_pending
                                      : st_reg.blocked)) begin
         st_next.wbuf[(tte_pkg::SLOT_BYTES-1-int'(spi_in.addr))*8 +: 8] =
            spi_in.data;
         if (spi_in.addr == tte_pkg::HOTSPOT_POS)
            st_next.saw_hot = 1'b1;
         if (spi_in.data != tte_pkg::FILL_BYTE)
            st_next.saw_non_ff = 1'b1;
      end
      if (spi_in.rd) begin
         st_next.rdata = buf_byte(st_reg.rbuf, spi_in.addr);
         if (spi_in.addr >= tte_pkg::RD_HOT_LO)
            st_next.receive_full = 1'b0;
      end
      // Software cancel: frees buffer and moves outgoing toggle on
      if (clr_send_pending_in && st_reg.send_pending) begin
         st_next.send_pending = 1'b0;
         st_next.out_toggle   = ~st_reg.out_toggle;
      end
      if (clr_receive_full_in)
         st_next.receive_full = 1'b0;
      if (clr_receive_full_in && st_reg.receive_full)
         st_next.in_active = 1'b0;
      if (clr_summary_in) begin
         st_next.sum_sent = 1'b0;
         st_next.sum_receive_full_flag = 1'b0;
      end
      // Completion of the host transfer; a non-idle slot with both FF
      // indexes still sets pending when any byte differs
      if (spi_in.stop && !st_next.blocked && st_next.saw_hot &&
          st_next.saw_non_ff)
         st_next.send_pending = 1'b1;
      // Matching acknowledgement terminates the transaction
      if (rx_valid_in && rx_ack_in && st_reg.send_pending &&
          (rx_ack_toggle_in == st_reg.out_toggle)) begin
         st_next.send_pending = 1'b0;
         st_next.sum_sent     = 1'b1;
         st_next.out_toggle   = ~st_reg.out_toggle;
      end
      // Accepted read slot: store, flag, load toggle, arm ack
      if (rx_accept) begin
         st_next.rbuf         = {rx_slot_in.item_hi, rx_slot_in.item_lo};
         st_next.receive_full = 1'b1;
         st_next.sum_receive_full_flag     = 1'b1;
         st_next.in_toggle    = rx_slot_in.toggle;
         st_next.in_active    = 1'b1;
      end
      // Ack once software has drained the buffer
      st_next.ack = st_reg.in_active && !st_reg.receive_full;
      if (frame_in) begin
         st_next.tx_valid = 1'b1;
         if (st_reg.send_pending)
            st_next.tx_slot = wslot;
         else begin
            st_next.tx_slot.item_hi.index = tte_pkg::IDLE_INDEX;
            st_next.tx_slot.item_hi.value = tte_pkg::IDLE_VALUE;
            st_next.tx_slot.item_lo.index = tte_pkg::IDLE_INDEX;
            st_next.tx_slot.item_lo.value = tte_pkg::IDLE_VALUE;
            st_next.tx_slot.toggle        = st_reg.out_toggle;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         st_reg              <= '0;
         st_reg.wbuf         <= '1;
         st_reg.send_pending <= tte_pkg::RST_FLAG;
         st_reg.receive_full <= tte_pkg::RST_FLAG;
         // Toggles reset to a fixed value but are not trusted until sync
         st_reg.out_toggle   <= tte_pkg::RST_TOGGLE;
         st_reg.in_toggle    <= tte_pkg::RST_TOGGLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign spi_rdata_out    = st_reg.rdata;
   assign send_pending_out = st_reg.send_pending;
   assign receive_full_out = st_reg.receive_full;
   assign summary_sent_out = st_reg.sum_sent;
   assign summary_receive_full_flag_out = st_reg.sum_receive_full_flag;
   assign tx_valid_out     = st_reg.tx_valid;
   assign tx_slot_out      = st_reg.tx_slot;
   assign ack_out          = st_reg.ack;
   assign ack_toggle_out   = st_reg.in_toggle;

   // Receive side, retransmission, cancel and host write gating
   chk_idle_no_flag: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (rx_valid_in && rx_idle && !st_reg.receive_full)
         |=> !st_reg.receive_full)
      else $error("idle slot set received flag");
   chk_cancel_toggle: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (clr_send_pending_in && st_reg.send_pending && !rx_ack_in
       && !spi_in.stop)
         |=> !st_reg.send_pending &&
             (st_reg.out_toggle != $past(st_reg.out_toggle)))
      else $error("cancel did not toggle outgoing bit");
   chk_ack_done: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (rx_valid_in && rx_ack_in && st_reg.send_pending &&
       rx_ack_toggle_in == st_reg.out_toggle && !spi_in.stop)
         |=> !st_reg.send_pending && st_reg.sum_sent)
      else $error("ack did not terminate transaction");
   chk_sync_load: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (rx_valid_in && rx_sync && !rx_idle && !st_reg.receive_full)
         |=> st_reg.receive_full &&
             st_reg.in_toggle == $past(rx_slot_in.toggle))
      else $error("sync slot toggle not loaded");
   chk_full_guard: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (st_reg.receive_full && !spi_in.rd && !clr_receive_full_in)
         |=> $stable(st_reg.rbuf))
      else $error("full buffer overwritten");
   chk_resend: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (frame_in && st_reg.send_pending)
         |=> tx_valid_out && tx_slot_out.toggle == $past(st_reg.out_toggle))
      else $error("pending slot not resent");
   chk_idle_send: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (frame_in && !st_reg.send_pending)
         |=> tx_slot_out.item_lo.index == tte_pkg::IDLE_INDEX &&
             tx_slot_out.item_hi.value == tte_pkg::IDLE_VALUE)
      else $error("idle slot malformed");
   chk_blocked_write: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (st_reg.send_pending && spi_in.wr && !spi_in.start &&
       st_reg.blocked) |=> $stable(st_reg.wbuf))
      else $error("write accepted while pending");
   chk_read_clear: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (spi_in.rd && spi_in.addr >= tte_pkg::RD_HOT_LO && !rx_valid_in)
         |=> !st_reg.receive_full)
      else $error("hotspot read kept received flag");

   // The received-flag clear must touch only the flag it names
   chk_clear_one: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (clr_receive_full_in && !rx_accept) |=> !st_reg.receive_full)
      else $error("received flag not cleared");
   chk_clear_keeps: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (clr_receive_full_in && !clr_send_pending_in && !spi_in.stop &&
       !rx_valid_in)
         |=> $stable(st_reg.send_pending) && $stable(st_reg.out_toggle))
      else $error("receive clear disturbed send state");
   // A dropped ack strands the node until a synchronizing slot is taken
   chk_clear_no_ack: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (clr_receive_full_in && st_reg.receive_full)
         |=> !st_reg.in_active ##1 !ack_out)
      else $error("ack returned after received flag clear");

   // Host transfer outcome and idle traffic
   chk_hot_pending: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (spi_in.stop && spi_in.wr && !spi_in.start && !st_reg.blocked &&
       spi_in.addr == tte_pkg::HOTSPOT_POS &&
       (st_reg.saw_non_ff || spi_in.data != tte_pkg::FILL_BYTE))
         |=> st_reg.send_pending)
      else $error("hotspot write did not set send-pending");
   chk_fill_no_pend: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (spi_in.stop && !spi_in.start && !st_reg.send_pending &&
       !st_reg.saw_non_ff && spi_in.data == tte_pkg::FILL_BYTE)
         |=> !st_reg.send_pending)
      else $error("all-fill transfer set send-pending");
   chk_idle_no_ack: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (rx_valid_in && rx_idle && !st_reg.in_active && !st_reg.sum_receive_full_flag)
         |=> !st_reg.in_active && !st_reg.sum_receive_full_flag)
      else $error("idle slot armed an acknowledgement");

   // Retransmission and toggle bookkeeping
   chk_hold_pending: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (rx_valid_in && st_reg.send_pending && !clr_send_pending_in &&
       !(rx_ack_in && rx_ack_toggle_in == st_reg.out_toggle))
         |=> st_reg.send_pending)
      else $error("unacknowledged slot dropped");
   chk_toggle_hold: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (!clr_send_pending_in && !rx_valid_in)
         |=> $stable(st_reg.out_toggle) && $stable(st_reg.in_toggle))
      else $error("toggle moved without an event");
endmodule // tte_engine
`default_nettype wire

/* rtl/tte_pkg.sv */
// Purpose: shared constants and carriers for the timeslot transaction engine
// Assumes: one write timeslot buffer holds two data items of 5 bytes each
// Notes:   item byte 0 is the index, bytes 1..4 the value, MSB first
package tte_pkg;
   localparam logic [7:0]  IDLE_INDEX   = 8'hFF;
   localparam logic [31:0] IDLE_VALUE   = 32'hFFFFFFFF;
   localparam logic [7:0]  SYNC_MIN     = 8'hF0;
   localparam logic [7:0]  FILL_BYTE    = 8'hFF;
   localparam int          ITEM_BYTES   = 5;
   localparam int          SLOT_BYTES   = 10;
   localparam logic [3:0]  HOTSPOT_POS  = 4'h9;
   localparam logic [3:0]  RD_HOT_LO    = 4'h8;
   localparam logic        RST_FLAG     = 1'b0;
   localparam logic        RST_TOGGLE   = 1'b0;

   typedef struct packed {
      logic [7:0]  index;
      logic [31:0] value;
   } tte_item_s;

   typedef struct packed {
      tte_item_s item_hi;
      tte_item_s item_lo;
      logic      toggle;
   } tte_slot_s;

   // Host byte-port transfer beat
   typedef struct packed {
      logic       start;
      logic       wr;
      logic       rd;
      logic       stop;
      logic [3:0] addr;
      logic [7:0] data;
   } tte_spi_s;
endpackage

/* testbench/tte_engine_bench.sv */
// Purpose: self-checking bench of the timeslot transaction engine
// Assumes: node model acknowledges like a real peer chip
// Notes:   waits follow the fixed latencies of the engine's ports
`timescale 1ns/10ps
`default_nettype none
module tte_engine_bench;
   localparam logic [39:0] IDL = 40'hFF_FFFF_FFFF;
   logic clk, rst, clr_sp, clr_rf, clr_sum, frame, ack_en, send;
   logic sp, rf, ss, sr, tx_v, rx_v, rx_ack, rx_atg, ack, ack_tg;
   logic [7:0] rdata;
   tte_pkg::tte_spi_s  spi;
   tte_pkg::tte_slot_s tx_slot, rx_slot, send_slot, s;
   int num_errors, num_checks;
   always #25 clk = ~clk;
   tte_engine u_tte_engine (.ref_clk_in(clk), .sys_rst_in(rst),
      .spi_in(spi), .spi_rdata_out(rdata), .clr_send_pending_in(clr_sp),
      .clr_receive_full_in(clr_rf), .clr_summary_in(clr_sum),
      .send_pending_out(sp), .receive_full_out(rf),
      .summary_sent_out(ss), .summary_receive_full_flag_out(sr), .frame_in(frame),
      .tx_valid_out(tx_v), .tx_slot_out(tx_slot), .rx_valid_in(rx_v),
      .rx_slot_in(rx_slot), .rx_ack_in(rx_ack), .rx_ack_toggle_in(rx_atg),
      .ack_out(ack), .ack_toggle_out(ack_tg));
   tte_node_model u_tte_node_model (.clk_in(clk), .rst_in(rst),
      .ack_en_in(ack_en), .send_in(send), .send_slot_in(send_slot),
      .tx_valid_in(tx_v), .tx_slot_in(tx_slot), .ack_in(ack),
      .ack_toggle_in(ack_tg), .rx_valid_out(rx_v), .rx_slot_out(rx_slot),
      .rx_ack_out(rx_ack), .rx_ack_toggle_out(rx_atg));
   task automatic chk(input string n, input logic [80:0] sn, ex);
      num_checks++;
      if (sn !== ex) begin
         $display("BAD %s expected %h seen %h", n, ex, sn);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [79:0] b);
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         spi <= {i == 0, 1'b1, 1'b0, i == 9, 4'(i), b[79-8*i -: 8]};
      end
      @(posedge clk);
      spi <= '0;
      #1;
   endtask
   // One frame, then wait until the node's answer has landed
   task automatic frm();
      @(posedge clk) frame <= 1'b1;
      @(posedge clk) frame <= 1'b0;
      #1 chk("tx_valid", tx_v, 1);
      s = tx_slot;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic clr(input logic [2:0] m);
      @(posedge clk) {clr_sp, clr_rf, clr_sum} <= m;
      @(posedge clk) {clr_sp, clr_rf, clr_sum} <= 3'h0;
      #1;
   endtask
   task automatic rq(input logic [80:0] v);
      @(posedge clk) send_slot <= v;
      send <= 1'b1;
      @(posedge clk) send <= 1'b0;
   endtask
   task automatic t_basic();
      chk("flags", {sp, rf, ss, sr}, 0);
      frm();
      chk("idle", s[80:1], {IDL, IDL});
      chk("pend", sp, 0);
      wr(80'h12_0000_00A1_34_0000_00B2);
      chk("pend", sp, 1);
      frm();
      chk("slot", s, {80'h12_0000_00A1_34_0000_00B2, 1'b0});
      chk("term", {sp, ss}, 2'b01);
      clr(3'h1);
      chk("sum", ss, 0);
      $display("test basic done");
   endtask
   task automatic t_cancel();
      ack_en <= 1'b0;
      wr(80'h21_0000_0001_22_0000_0002);
      wr(80'h31_0000_0003_32_0000_0004);
      frm();
      chk("keep", s, {80'h21_0000_0001_22_0000_0002, 1'b1});
      frm();
      chk("again", s[80:1], 80'h21_0000_0001_22_0000_0002);
      clr(3'h4);
      chk("cancel", {sp, ss}, 0);
      wr(80'h41_0000_0005_42_0000_0006);
      frm();
      chk("flip", s[0], 0);
      clr(3'h4);
      ack_en <= 1'b1;
      wr({8'hFF, 32'h0, IDL});
      chk("ffix", sp, 1);
      frm();
      chk("noack", sp, 1);
      clr(3'h4);
      wr({IDL, IDL});
      chk("fill", sp, 0);
      wr(80'hF5_0000_0001_F5_0000_0002);
      frm();
      chk("sync", {s[0], sp, ss}, 3'b001);
      clr(3'h1);
      $display("test cancel done");
   endtask
   task automatic t_recv();
      rq({80'h10_0000_1111_11_0000_2233, 1'b1});
      frm();
      chk("rcv", {rf, sr, ack}, 3'b110);
      @(posedge clk) spi <= {1'b1, 1'b0, 1'b1, 1'b1, 4'h8, 8'h00};
      @(posedge clk) spi <= '0;
      #1 chk("rdata", rdata, 8'h22);
      chk("hot", rf, 0);
      @(posedge clk) #1 chk("ack", {ack, ack_tg}, 2'b11);
      frm();
      frm();
      chk("idle", rf, 0);
      rq({80'h50_0000_0007_51_0000_0008, 1'b0});
      frm();
      chk("rcv2", rf, 1);
      clr(3'h2);
      chk("clr", rf, 0);
      frm();
      chk("drop", {rf, ack}, 0);
      // Sync read slot is taken although its toggle repeats
      rq({80'hF0_0000_0009_F1_0000_000A, 1'b0});
      frm();
      chk("rsync", {rf, ack_tg}, 2'b10);
      @(posedge clk) spi <= {1'b1, 1'b0, 1'b1, 1'b1, 4'h9, 8'h00};
      @(posedge clk) spi <= '0;
      #1 chk("rsync data", rdata, 8'h0A);
      $display("test recv done");
   endtask
   task results();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {clk, rst, clr_sp, clr_rf, clr_sum, frame, send} = 7'h20;
      ack_en = 1'b1;
      spi = '0;
      send_slot = '0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_basic();
      t_cancel();
      t_recv();
      results();
   end
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule // tte_engine_bench
`default_nettype wire

/* testbench/tte_node_model.sv */
// Purpose: peer node on the link side, answering the engine's write slots
// Assumes: node software reads at once, so its receive flags stay clear
// Notes:   one queued read slot, retried until the engine acknowledges it
`timescale 1ns/10ps
`default_nettype none
module tte_node_model (
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   // Bench control
   input  wire logic               ack_en_in,
   input  wire logic               send_in,
   input  wire tte_pkg::tte_slot_s send_slot_in,
   // From the engine
   input  wire logic               tx_valid_in,
   input  wire tte_pkg::tte_slot_s tx_slot_in,
   input  wire logic               ack_in,
   input  wire logic               ack_toggle_in,
   // To the engine
   output logic                    rx_valid_out,
   output tte_pkg::tte_slot_s      rx_slot_out,
   output logic                    rx_ack_out,
   output logic                    rx_ack_toggle_out
);
   logic       last_tg, rd_tg, pend, idle_ix, sync, done, tg;
   assign tg = tx_slot_in.toggle;
   assign idle_ix = tx_slot_in.item_hi.index == 8'hFF &&
                    tx_slot_in.item_lo.index == 8'hFF;
   assign sync = tx_slot_in.item_hi.index >= 8'hF0 &&
                 tx_slot_in.item_lo.index >= 8'hF0;
   assign done = pend && ack_in && ack_toggle_in == rd_tg;
   always @(posedge clk_in) begin
      rx_valid_out <= 1'b0;
      rx_ack_out <= 1'b0;
      // Released bus alternates each cycle between the inverse of the last slot and the last slot
      rx_slot_out <= ~rx_slot_out;
      if (send_in) pend <= 1'b1;
      if (rst_in) begin
         // Nothing queued; toggles start unaligned with the engine
         {last_tg, rd_tg, pend, rx_ack_toggle_out} <= 4'hC;
         rx_slot_out <= '0;
      end else if (tx_valid_in) begin
         rx_valid_out <= 1'b1;
         rx_slot_out <= (pend && !done) ? {send_slot_in[80:1], rd_tg}
                        : {80'hFFFF_FFFF_FFFF_FFFF_FFFF, rd_tg};
         rx_ack_out <= ack_en_in && !idle_ix;
         rx_ack_toggle_out <= last_tg;
         if (ack_en_in && !idle_ix && (sync || tg != last_tg)) begin
            last_tg <= tg;
            rx_ack_toggle_out <= tg;
         end
         if (done) begin
            pend <= 1'b0;
            rd_tg <= !rd_tg;
         end
      end
   end
endmodule // tte_node_model
`default_nettype wire
